// *** rtl/csp_clock_ctrl.sv ***
// Clock control: PLL enable and bypass, divided system and bus clock enables,
// pixel phase accumulator, horizontal sync re-phasing, refresh tick, registers.
// Assumes the PLL is modelled as CLK_SYS_I plus enable pulses standing for clocks.
//
// Implementation choices: the address map and the plain strobed port.
`include "csp_defs.svh"
`timescale 1ns/10ps
`default_nettype none
module csp_clock_ctrl #(
    parameter int PIX_ACC_W = `CSP_ACC_W
) (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic [`CSP_ADDR_W-1:0] ADDR_I,
    input wire logic [15:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [15:0] RDATA_O,
    input wire logic END_OF_INIT_INSTRUCTION_I,
    input wire logic HSYNC_I,
    input wire logic VSYNC_I,
    output logic HSYNC_O,
    output logic VSYNC_O,
    output logic PLL_EN_O,
    output logic PLL_BYPASS_O,
    output logic SYS_TICK_O,
    output logic BUS_TICK_O,
    output logic BUS_FAST_O,
    output logic PIX_TICK_O,
    output logic REFRESH_O
);
    // ============================================================
    // Registers
    logic [15:0] syscfg_reg, syscfg_next;
    logic [`CSP_PIXFAC_W-1:0] pixfac_reg, pixfac_next;
    logic [2:0] ctrl_reg, ctrl_next;
    logic [15:0] hper_reg, hper_next;
    logic locked_reg, locked_next;
    logic [15:0] rdata_reg, rdata_next;
    csp_pkg::csp_power_type pwr;

    always_comb begin
        syscfg_next = syscfg_reg;
        pixfac_next = pixfac_reg;
        ctrl_next = ctrl_reg;
        hper_next = hper_reg;
        locked_next = locked_reg | END_OF_INIT_INSTRUCTION_I;
        rdata_next = 16'h0000;
        if (WR_I) begin
            case (ADDR_I)
                `CSP_OFF_SYSCFG: begin
                    if (!locked_reg) begin
                        syscfg_next = 16'h0000;
                        syscfg_next[`CSP_BUSSEL_BIT] = WDATA_I[`CSP_BUSSEL_BIT];
                    end
                end
                `CSP_OFF_PIXFAC: pixfac_next = WDATA_I[`CSP_PIXFAC_W-1:0];
                `CSP_OFF_CTRL: ctrl_next = WDATA_I[2:0];
                `CSP_OFF_HPERIOD: hper_next = WDATA_I;
                default: ;
            endcase
        end
        if (RD_I) begin
            case (ADDR_I)
                `CSP_OFF_SYSCFG: rdata_next = syscfg_reg;
                `CSP_OFF_PIXFAC: rdata_next = {5'h00, pixfac_reg};
                `CSP_OFF_CTRL: rdata_next = {13'h0000, ctrl_reg};
                `CSP_OFF_STATUS: rdata_next = {12'h000, locked_reg, BUS_FAST_O,
                                               PLL_BYPASS_O, PLL_EN_O};
                `CSP_OFF_HPERIOD: rdata_next = hper_reg;
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            syscfg_reg <= `CSP_SYSCFG_RESET;
            pixfac_reg <= `CSP_PIXFAC_RESET;
            ctrl_reg <= 3'h0;
            hper_reg <= `CSP_HPERIOD_RESET;
            locked_reg <= 1'b0;
            rdata_reg <= 16'h0000;
        end else begin
            syscfg_reg <= syscfg_next;
            pixfac_reg <= pixfac_next;
            ctrl_reg <= ctrl_next;
            hper_reg <= hper_next;
            locked_reg <= locked_next;
            rdata_reg <= rdata_next;
        end
    end
    assign RDATA_O = rdata_reg;

    // ============================================================
    // Power modes
    always_comb begin
        if (ctrl_reg[`CSP_CTRL_SLEEP]) begin
            pwr = csp_pkg::CSP_SLEEP;
        end else if (ctrl_reg[`CSP_CTRL_IDLE]) begin
            pwr = csp_pkg::CSP_IDLE;
        end else begin
            pwr = csp_pkg::CSP_RUN;
        end
    end

    logic pll_en_reg, pll_en_next, byp_reg, byp_next;
    logic byp_want;
    always_comb begin
        case (pwr)
            csp_pkg::CSP_IDLE: begin
                pll_en_next = 1'b1;
                byp_want = 1'b1;
            end
            csp_pkg::CSP_SLEEP: begin
                // The PLL stops only once the system domain already runs from the bypass.
                pll_en_next = ~byp_reg;
                byp_want = 1'b1;
            end
            default: begin
                pll_en_next = 1'b1;
                byp_want = 1'b0;
            end
        endcase
    end

    // ============================================================
    // Divided clocks
    // Rate changes and bypass take effect only at a divider wrap, so no runt.
    logic [4:0] sys_cnt_reg, sys_cnt_next;
    logic [3:0] bus_cnt_reg, bus_cnt_next;
    logic fast_reg, fast_next;
    logic sys_wrap, bus_wrap;
    always_comb begin
        sys_wrap = (sys_cnt_reg == 5'(`CSP_SYS_DIV - 1));
        sys_cnt_next = sys_wrap ? 5'h00 : sys_cnt_reg + 5'h01;
        bus_wrap = (bus_cnt_reg == (fast_reg ? 4'(`CSP_BUS_HI_DIV - 1)
                                              : 4'(`CSP_BUS_LO_DIV - 1)));
        bus_cnt_next = bus_wrap ? 4'h0 : bus_cnt_reg + 4'h1;
        fast_next = bus_wrap ? syscfg_reg[`CSP_BUSSEL_BIT] : fast_reg;
        byp_next = sys_wrap ? byp_want : byp_reg;
    end

    // ============================================================
    // Refresh interval
    logic [10:0] ref_cnt_reg, ref_cnt_next;
    logic ref_reg, ref_next;
    always_comb begin
        ref_cnt_next = ref_cnt_reg;
        ref_next = 1'b0;
        if (bus_wrap) begin
            if (ref_cnt_reg >= (fast_reg ? 11'(`CSP_REFRESH_HI - 1)
                                          : 11'(`CSP_REFRESH_LO - 1))) begin
                ref_cnt_next = 11'h000;
                ref_next = 1'b1;
            end else begin
                ref_cnt_next = ref_cnt_reg + 11'h001;
            end
        end
    end

    // ============================================================
    // Sync inputs and pixel accumulator
    logic [1:0] hs_sync_reg, vs_sync_reg;
    logic hs_old_reg;
    logic [15:0] hcnt_reg, hcnt_next;
    logic hs_gen_reg, hs_gen_next, vs_gen_reg;
    logic [PIX_ACC_W-1:0] acc_reg, acc_next;
    logic pix_reg, pix_next;
    logic hs_rise;
    logic [PIX_ACC_W:0] acc_sum;
    always_comb begin
        hcnt_next = (hcnt_reg >= hper_reg) ? 16'h0000 : hcnt_reg + 16'h0001;
        hs_gen_next = ctrl_reg[`CSP_CTRL_MASTER] && (hcnt_reg == 16'h0000);
        hs_rise = ctrl_reg[`CSP_CTRL_MASTER] ? hs_gen_next
                                              : (hs_sync_reg[1] & ~hs_old_reg);
        acc_sum = {1'b0, acc_reg} + (PIX_ACC_W + 1)'(pixfac_reg);
        acc_next = acc_sum[PIX_ACC_W-1:0];
        pix_next = acc_sum[PIX_ACC_W];
        if (hs_rise) begin
            acc_next = (PIX_ACC_W)'(pixfac_reg);
            pix_next = 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge RESET_N_I) begin
        if (!RESET_N_I) begin
            pll_en_reg <= 1'b1;
            byp_reg <= 1'b0;
            sys_cnt_reg <= 5'h00;
            bus_cnt_reg <= 4'h0;
            fast_reg <= 1'b0;
            ref_cnt_reg <= 11'h000;
            ref_reg <= 1'b0;
            hs_sync_reg <= 2'b00;
            vs_sync_reg <= 2'b00;
            hs_old_reg <= 1'b0;
            hcnt_reg <= 16'h0000;
            hs_gen_reg <= 1'b0;
            vs_gen_reg <= 1'b0;
            acc_reg <= '0;
            pix_reg <= 1'b0;
        end else begin
            pll_en_reg <= pll_en_next;
            byp_reg <= byp_next;
            sys_cnt_reg <= sys_cnt_next;
            bus_cnt_reg <= bus_cnt_next;
            fast_reg <= fast_next;
            ref_cnt_reg <= ref_cnt_next;
            ref_reg <= ref_next;
            hs_sync_reg <= {hs_sync_reg[0], HSYNC_I};
            vs_sync_reg <= {vs_sync_reg[0], VSYNC_I};
            hs_old_reg <= hs_sync_reg[1];
            hcnt_reg <= hcnt_next;
            hs_gen_reg <= hs_gen_next;
            vs_gen_reg <= vs_sync_reg[1];
            acc_reg <= acc_next;
            pix_reg <= pix_next;
        end
    end

    assign PIX_TICK_O = pix_reg & pll_en_reg;
    assign PLL_EN_O = pll_en_reg;
    assign PLL_BYPASS_O = byp_reg;
    assign SYS_TICK_O = sys_wrap;
    assign BUS_TICK_O = bus_wrap;
    assign BUS_FAST_O = fast_reg;
    assign REFRESH_O = ref_reg;
    assign HSYNC_O = hs_gen_reg;
    assign VSYNC_O = ctrl_reg[`CSP_CTRL_MASTER] & vs_gen_reg;
endmodule : csp_clock_ctrl
`default_nettype wire

// *** rtl/csp_defs.svh ***
// Constants of the clock control block: register offsets, fields, resets, rates.
// Assumes a plain register port; the RTL uses these names, but the checker and bench also hard-code figures.
`ifndef CSP_DEFS_SVH
`define CSP_DEFS_SVH
// ============================================================
// Register map
`define CSP_ADDR_W 4
`define CSP_OFF_SYSCFG 4'h0
`define CSP_OFF_PIXFAC 4'h1
`define CSP_OFF_CTRL 4'h2
`define CSP_OFF_STATUS 4'h3
`define CSP_OFF_HPERIOD 4'h4
`define CSP_SYSCFG_RESET 16'h0000
`define CSP_PIXFAC_RESET 11'h148
`define CSP_HPERIOD_RESET 16'h0A00
`define CSP_BUSSEL_BIT 8
`define CSP_PIXFAC_W 11
// Control register bits.
`define CSP_CTRL_IDLE 0
`define CSP_CTRL_SLEEP 1
`define CSP_CTRL_MASTER 2
// ============================================================
// Clock rates and dividers
`define CSP_PLL_MHZ 600
`define CSP_SYS_MHZ 33
`define CSP_BUS_LO_MHZ 66
`define CSP_BUS_HI_MHZ 100
`define CSP_PIX_REF_MHZ 300
`define CSP_SYS_DIV 18
`define CSP_BUS_LO_DIV 9
`define CSP_BUS_HI_DIV 6
`define CSP_ACC_W 13
`define CSP_REFRESH_NS 7800
`define CSP_REFRESH_LO ((`CSP_REFRESH_NS * `CSP_BUS_LO_MHZ) / 1000)
`define CSP_REFRESH_HI ((`CSP_REFRESH_NS * `CSP_BUS_HI_MHZ) / 1000)
`endif

// *** rtl/csp_pkg.sv ***
// Types of the clock control block.
// Assumes csp_defs.svh supplies the numbers.
package csp_pkg;
    typedef enum logic [1:0] {CSP_RUN, CSP_IDLE, CSP_SLEEP} csp_power_type;
endpackage : csp_pkg

// *** test/csp_sync_src.sv ***
// Display-side sync source driving the slave sync inputs.
// Assumes the block's clock; both lines idle low while disabled.
`timescale 1ns/10ps
`default_nettype none
module csp_sync_src #(
    parameter int LINE = 64
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic en_i,
    output logic hsync_o,
    output logic vsync_o
);
    // ============================================================
    // Line and field counters
    logic [15:0] pos_reg;
    logic [3:0] line_reg;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_reg <= 16'h0000;
            line_reg <= 4'h0;
        end else if (en_i) begin
            pos_reg <= (pos_reg == 16'(LINE - 1)) ? 16'h0000 : pos_reg + 16'h0001;
            if (pos_reg == 16'(LINE - 1)) line_reg <= line_reg + 4'h1;
        end
    end
    assign hsync_o = en_i && pos_reg < 16'h0004;
    assign vsync_o = en_i && line_reg == 4'h0;
endmodule : csp_sync_src
`default_nettype wire

// *** test/csp_clock_asserts.sv ***
// Port timing checker of the clock control block.
// Assumes it is bound to csp_clock_ctrl and sees its ports only.
`timescale 1ns/10ps
`default_nettype none
module csp_clock_asserts (
    input wire logic CLK_SYS_I,
    input wire logic RESET_N_I,
    input wire logic RD_I,
    input wire logic HSYNC_I,
    input wire logic [15:0] RDATA_O,
    input wire logic HSYNC_O,
    input wire logic PLL_EN_O,
    input wire logic PLL_BYPASS_O,
    input wire logic SYS_TICK_O,
    input wire logic BUS_TICK_O,
    input wire logic BUS_FAST_O,
    input wire logic PIX_TICK_O,
    input wire logic REFRESH_O
);
    // ============================================================
    // Properties
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!RESET_N_I);
    sequence s_slow; BUS_TICK_O && !BUS_FAST_O ##1 !BUS_FAST_O; endsequence
    sequence s_fast; BUS_TICK_O && BUS_FAST_O ##1 BUS_FAST_O; endsequence
    property p_rdata_idle; !$past(RD_I) |-> RDATA_O == 16'h0000; endproperty
    a_rdata_idle: assert property (p_rdata_idle) else $error("read data not idle");
    property p_sys_period; SYS_TICK_O && !PLL_BYPASS_O |-> ##18 SYS_TICK_O; endproperty
    a_sys_period: assert property (p_sys_period) else $error("system tick period");
    property p_bus_slow; s_slow |-> ##8 BUS_TICK_O; endproperty
    a_bus_slow: assert property (p_bus_slow) else $error("slow bus period");
    property p_bus_fast; s_fast |-> ##5 BUS_TICK_O; endproperty
    a_bus_fast: assert property (p_bus_fast) else $error("fast bus period");
    property p_sleep_bypass; $fell(PLL_EN_O) |-> PLL_BYPASS_O; endproperty
    a_sleep_bypass: assert property (p_sleep_bypass) else $error("sleep without bypass");
    property p_refresh_gap; REFRESH_O |=> !REFRESH_O [*8]; endproperty
    a_refresh_gap: assert property (p_refresh_gap) else $error("refresh too close");
    property p_hsync_pulse; HSYNC_O |=> !HSYNC_O; endproperty
    a_hsync_pulse: assert property (p_hsync_pulse) else $error("line pulse too long");
    property p_pix_slave; $rose(HSYNC_I) |-> ##[1:5] PIX_TICK_O; endproperty
    a_pix_slave: assert property (p_pix_slave) else $error("no slave re-phase");
    property p_pix_master; $rose(HSYNC_O) |-> ##[0:3] PIX_TICK_O; endproperty
    a_pix_master: assert property (p_pix_master) else $error("no master re-phase");
endmodule : csp_clock_asserts
bind csp_clock_ctrl csp_clock_asserts u_csp_clock_asserts (.CLK_SYS_I(CLK_SYS_I),
    .RESET_N_I(RESET_N_I), .RD_I(RD_I), .HSYNC_I(HSYNC_I), .RDATA_O(RDATA_O),
    .HSYNC_O(HSYNC_O), .PLL_EN_O(PLL_EN_O), .PLL_BYPASS_O(PLL_BYPASS_O),
    .SYS_TICK_O(SYS_TICK_O), .BUS_TICK_O(BUS_TICK_O), .BUS_FAST_O(BUS_FAST_O),
    .PIX_TICK_O(PIX_TICK_O), .REFRESH_O(REFRESH_O));
`default_nettype wire

// *** test/csp_clock_ctrl_tb.sv ***
// Self-checking bench of the clock control block.
// Assumes the sync source model stands for the display side.
`include "csp_defs.svh"
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) chk(n, 16'(e), 16'(g))
module csp_clock_ctrl_tb;
    // ============================================================
    // Bench
    localparam int ACC = 13;
    localparam int PF = 1366;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [15:0] wdata = 16'h0000;
    logic wr = 1'b0, rd = 1'b0, end_of_init_instruction = 1'b0, sync_en = 1'b0;
    logic [15:0] rdata;
    logic hs_in, vs_in, hs_o, vs_o, pll_en, bypass, sys_t, bus_t, fast, pix_t, refr;
    int n_errors = 0;
    int check_count = 0;
    int cyc = 0;
    initial begin
        forever #5 clk = ~clk;
    end
    csp_clock_ctrl #(.PIX_ACC_W(ACC)) u_csp_clock_ctrl (.CLK_SYS_I(clk), .RESET_N_I(rst_n),
        .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
        .END_OF_INIT_INSTRUCTION_I(end_of_init_instruction), .HSYNC_I(hs_in), .VSYNC_I(vs_in), .HSYNC_O(hs_o), .VSYNC_O(vs_o),
        .PLL_EN_O(pll_en), .PLL_BYPASS_O(bypass), .SYS_TICK_O(sys_t), .BUS_TICK_O(bus_t),
        .BUS_FAST_O(fast), .PIX_TICK_O(pix_t), .REFRESH_O(refr));
    csp_sync_src #(.LINE(64)) u_csp_sync_src (.clk_i(clk), .rst_n_i(rst_n), .en_i(sync_en),
        .hsync_o(hs_in), .vsync_o(vs_in));
    task chk(input string n, input logic [15:0] e, input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", n, e, g);
            n_errors++;
        end
    endtask : chk
    task stop_test;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : stop_test
    task wr_reg(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg
    task rd_reg(input logic [3:0] a, input logic [15:0] e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 `CHK("rdata", e, rdata);
    endtask : rd_reg
    task bus_gap(input bit pick_r, output int n);
        n = 0;
        @(negedge clk);
        while ((pick_r ? refr : bus_t) !== 1'b1) @(negedge clk);
        do begin
            @(negedge clk);
            n++;
        end while ((pick_r ? refr : bus_t) !== 1'b1);
    endtask : bus_gap
    task count_pulses(input bit pick_h, input int len, output int n);
        n = 0;
        repeat (len) begin
            @(negedge clk);
            if ((pick_h ? hs_o : pix_t) === 1'b1) n++;
        end
    endtask : count_pulses
    task t_reset;
        int g;
        wr_reg(`CSP_OFF_HPERIOD, 16'h0063);
        rd_reg(`CSP_OFF_SYSCFG, `CSP_SYSCFG_RESET);
        rd_reg(`CSP_OFF_PIXFAC, 16'h0148);
        rd_reg(4'hF, 16'h0000);
        `CHK("pll_en", 1'b1, pll_en);
        bus_gap(1'b0, g);
        `CHK("slow_gap", `CSP_BUS_LO_DIV, g);
        bus_gap(1'b1, g);
        `CHK("refresh_slow", `CSP_REFRESH_LO * `CSP_BUS_LO_DIV, g);
    endtask : t_reset
    task t_select;
        int g;
        wr_reg(`CSP_OFF_SYSCFG, 16'h0100);
        rd_reg(`CSP_OFF_SYSCFG, 16'h0100);
        repeat (20) @(negedge clk);
        `CHK("bus_fast", 1'b1, fast);
        bus_gap(1'b0, g);
        `CHK("fast_gap", `CSP_BUS_HI_DIV, g);
        bus_gap(1'b1, g);
        `CHK("refresh_fast", `CSP_REFRESH_HI * `CSP_BUS_HI_DIV, g);
    endtask : t_select
    task t_lock;
        @(posedge clk);
        addr <= `CSP_OFF_SYSCFG;
        wdata <= 16'h0000;
        wr <= 1'b1;
        end_of_init_instruction <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        end_of_init_instruction <= 1'b0;
        rd_reg(`CSP_OFF_SYSCFG, 16'h0000);
        wr_reg(`CSP_OFF_SYSCFG, 16'h0100);
        rd_reg(`CSP_OFF_SYSCFG, 16'h0000);
        repeat (10) @(posedge clk);
        rd_reg(`CSP_OFF_STATUS, 16'h0009);
    endtask : t_lock
    task t_power;
        wr_reg(`CSP_OFF_CTRL, 16'h0001);
        repeat (40) @(negedge clk);
        `CHK("idle", 2'b11, {pll_en, bypass});
        wr_reg(`CSP_OFF_CTRL, 16'h0002);
        repeat (40) @(negedge clk);
        `CHK("sleep", 2'b01, {pll_en, bypass});
        wr_reg(`CSP_OFF_CTRL, 16'h0000);
        repeat (40) @(negedge clk);
        `CHK("run", 2'b10, {pll_en, bypass});
    endtask : t_power
    task t_pixel;
        int n;
        wr_reg(`CSP_OFF_PIXFAC, 16'hFD56);
        rd_reg(`CSP_OFF_PIXFAC, 16'h0556);
        wr_reg(`CSP_OFF_PIXFAC, 16'(PF));
        count_pulses(1'b0, 2 ** ACC, n);
        `CHK("pix_rate", 1'b1, n >= PF - 1 && n <= PF + 1);
    endtask : t_pixel
    task t_sync;
        int n;
        @(posedge clk);
        sync_en <= 1'b1;
        count_pulses(1'b1, 640, n);
        `CHK("slave_vs", 1'b0, vs_o);
        @(posedge clk);
        sync_en <= 1'b0;
        `CHK("slave_hs", 16'h0000, n);
        wr_reg(`CSP_OFF_CTRL, 16'h0004);
        repeat (200) @(negedge clk);
        count_pulses(1'b1, 1000, n);
        `CHK("master_hs", 16'h000A, n);
    endtask : t_sync
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_select();
        t_lock();
        t_power();
        t_pixel();
        t_sync();
        stop_test();
    end
endmodule : csp_clock_ctrl_tb
`default_nettype wire
